// file: rtl/afs_fifo.sv
`timescale 1ns/10ps
`include "afs_map.svh"
module afs_fifo #(
  parameter int WIDTH = `AFS_RES_W,
  parameter int DEPTH = `AFS_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic reset,
  afs_fifo_if.fifo bus
);
  import afs_pkg::*;
  localparam int AW = $clog2(DEPTH);

  // Pointers wrap naturally, so the depth must be a power of two
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
      $error("afs_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic full_r;
  logic empty_r;
  logic [WIDTH-1:0] rd_data_r;
  wire push = bus.in_valid & ~full_r;
  wire pop = bus.out_ready & ~empty_r;
  wire [AW:0] count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // Flags are registered so the ready and valid seen outside are flop outputs
  assign bus.in_ready = ~full_r;
  assign bus.out_valid = ~empty_r;
  assign bus.out_data = rd_data_r;

  // Storage and registered read port; data follows a pop by one cycle
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_r] <= bus.in_data;
    end
    if (pop) begin
      rd_data_r <= mem[rd_ptr_r];
    end
  end

  // Pointer and level bookkeeping
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      full_r <= 1'b0;
      empty_r <= 1'b1;
    end else begin
      wr_ptr_r <= wr_ptr_r + AW'(push);
      rd_ptr_r <= rd_ptr_r + AW'(pop);
      count_r <= count_nxt;
      full_r <= (count_nxt == (AW+1)'(DEPTH));
      empty_r <= (count_nxt == '0);
    end
  end
endmodule

// file: rtl/afs_fifo_if.sv
`timescale 1ns/10ps
interface afs_fifo_if #(parameter int WIDTH = 16);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// file: rtl/afs_map.svh
`ifndef AFS_MAP_SVH
`define AFS_MAP_SVH
// Pin vector positions after synchronisation
`define AFS_PIN_CS 0
`define AFS_PIN_FS 1
`define AFS_PIN_SCLK 2
`define AFS_PIN_SDI 3
`define AFS_PIN_TRIG 4
`define AFS_PIN_COUNT 5
// Idle levels of the pins: select and trigger high, the rest low
`define AFS_PIN_RST 5'h11
// Serial frame geometry
`define AFS_EDGE_CNT_W 4
`define AFS_CMD_BITS 16
`define AFS_EDGE_LAST 4'hF
// Result buffer defaults
`define AFS_RES_W 16
`define AFS_FIFO_DEPTH 32
`endif

// file: rtl/afs_pkg.sv
package afs_pkg;
  // Frame sequencer states
  typedef enum logic [1:0] {
    AFS_IDLE = 2'b00,
    AFS_ARMED = 2'b01,
    AFS_ACTIVE = 2'b10,
    AFS_DONE = 2'b11
  } afs_frame_state_t;
endpackage

// file: rtl/afs_top.sv
`timescale 1ns/10ps
`include "afs_map.svh"
// Behaviour
// - Select high: output released, command bits ignored
// - Select high: no shifting; conversion clock continues
// - Select fall clears counter, enables, drives output
// - Sync high at select fall starts cycle
// - Sync low at fall: start on sync rise
// - Trigger fall starts sampling in extended mode
// - Trigger rise holds sample, starts conversion
// - Sampling lasts exactly while trigger stays low
// - Trigger acts regardless of clock, select, sync
// - Command input stops at sixteen edges or deselect
// - End-of-conversion low from sampling end to ready
module afs_top #(
  parameter int RES_W = `AFS_RES_W,
  parameter int FIFO_DEPTH = `AFS_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic frame_select_n,
  input wire logic frame_sync_pulse,
  input wire logic shift_clk,
  input wire logic serial_command_in,
  input wire logic sample_trigger_n,
  input wire logic ext_sampling_mode,
  input wire logic ext_conv_clk_sel,
  input wire logic eoc_enable,
  input wire logic conv_done,
  input wire logic result_valid,
  input wire logic [RES_W-1:0] result_data,
  output logic result_ready,
  output logic serial_result_out,
  output logic serial_result_oe_n,
  output logic [`AFS_CMD_BITS-1:0] cmd_word,
  output logic cmd_valid,
  output logic sampling,
  output logic conv_start,
  output logic eoc_n,
  output logic conv_clk_tick,
  output afs_pkg::afs_frame_state_t frame_state
);
  import afs_pkg::*;

  generate
    if (RES_W < 2 || RES_W > 32) begin : g_bad_width
      $error("afs_top: RES_W must lie between 2 and 32");
    end
  endgenerate

  // Three-stage synchronisers with agreement filter on every pin
  localparam int NP = `AFS_PIN_COUNT;
  localparam logic [NP-1:0] PIN_RST = `AFS_PIN_RST;
  wire [NP-1:0] pin_raw = {sample_trigger_n, serial_command_in, shift_clk,
                           frame_sync_pulse, frame_select_n};
  wire [NP-1:0] pin_f_r;
  wire [NP-1:0] pin_d_r;
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_sync
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic f_r;
      logic d_r;
      // Each lane owns its flops; the vectors are only wired views of them
      assign pin_f_r[gi] = f_r;
      assign pin_d_r[gi] = d_r;
      // A change counts only once the last two stages agree
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          s1_r <= PIN_RST[gi];
          s2_r <= PIN_RST[gi];
          s3_r <= PIN_RST[gi];
          f_r <= PIN_RST[gi];
          d_r <= PIN_RST[gi];
        end else begin
          s1_r <= pin_raw[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          f_r <= (s2_r == s3_r) ? s3_r : f_r;
          d_r <= f_r;
        end
      end
    end
  endgenerate

  // Filtered levels and edges
  wire cs_f = pin_f_r[`AFS_PIN_CS];
  wire fs_f = pin_f_r[`AFS_PIN_FS];
  wire sdi_f = pin_f_r[`AFS_PIN_SDI];
  wire trig_f = pin_f_r[`AFS_PIN_TRIG];
  wire cs_fall = pin_d_r[`AFS_PIN_CS] & ~cs_f;
  wire fs_rise = ~pin_d_r[`AFS_PIN_FS] & fs_f;
  wire sclk_rise = ~pin_d_r[`AFS_PIN_SCLK] & pin_f_r[`AFS_PIN_SCLK];
  wire sclk_fall = pin_d_r[`AFS_PIN_SCLK] & ~pin_f_r[`AFS_PIN_SCLK];
  wire trig_fall = pin_d_r[`AFS_PIN_TRIG] & ~trig_f;
  wire trig_rise = ~pin_d_r[`AFS_PIN_TRIG] & trig_f;

  // Result buffer between the conversion engine and the shifter
  afs_fifo_if #(.WIDTH(RES_W)) rbuf ();
  logic pop_r;
  logic load_r;
  logic arm_r;
  logic got_r;
  assign rbuf.in_valid = result_valid;
  assign rbuf.in_data = result_data;
  assign rbuf.out_ready = pop_r;

  afs_fifo #(.WIDTH(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .bus(rbuf)
  );

  afs_frame_state_t state_r;
  logic [`AFS_EDGE_CNT_W-1:0] edge_cnt_r;
  logic edge_full_r;
  logic [`AFS_CMD_BITS-1:0] cmd_sh_r;
  logic [`AFS_CMD_BITS-1:0] cmd_word_r;
  logic cmd_valid_r;
  logic [RES_W-1:0] res_sh_r;
  logic sdo_r;
  logic oe_n_r;
  logic ready_r;

  // Frame sequencing decode; deselect always wins over everything else
  wire start_now = cs_fall & fs_f;
  wire active = (state_r == AFS_ACTIVE) & ~cs_f;
  wire take_bit = active & sclk_fall & ~edge_full_r;
  wire last_bit = take_bit & (edge_cnt_r == `AFS_EDGE_LAST);
  wire go_active = start_now | ((state_r == AFS_ARMED) & ~cs_f & fs_rise);
  afs_frame_state_t state_nxt;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      AFS_IDLE: begin
        if (start_now) begin
          state_nxt = AFS_ACTIVE;
        end else if (cs_fall) begin
          state_nxt = AFS_ARMED;
        end
      end
      AFS_ARMED: begin
        if (go_active) begin
          state_nxt = AFS_ACTIVE;
        end
      end
      AFS_ACTIVE: begin
        if (last_bit) begin
          state_nxt = AFS_DONE;
        end
      end
      AFS_DONE: begin
        state_nxt = AFS_DONE;
      end
      default: begin
        state_nxt = AFS_IDLE;
      end
    endcase
    if (cs_f) begin
      state_nxt = AFS_IDLE;
    end
  end

  // Command shifter: a bit is latched on each shift clock fall of a live frame
  wire [`AFS_CMD_BITS-1:0] cmd_sh_nxt = {cmd_sh_r[`AFS_CMD_BITS-2:0], sdi_f};
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r <= AFS_IDLE;
      edge_cnt_r <= '0;
      edge_full_r <= 1'b0;
      cmd_sh_r <= '0;
      cmd_word_r <= '0;
      cmd_valid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (cs_fall) begin
        edge_cnt_r <= '0;
        edge_full_r <= 1'b0;
      end else if (take_bit) begin
        edge_cnt_r <= edge_cnt_r + 1'b1;
        edge_full_r <= last_bit;
      end
      if (take_bit) begin
        cmd_sh_r <= cmd_sh_nxt;
      end
      if (last_bit) begin
        cmd_word_r <= cmd_sh_nxt;
      end
      cmd_valid_r <= last_bit;
    end
  end

  // Result shifter: word fetched at frame start, MSB out before first rise
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pop_r <= 1'b0;
      load_r <= 1'b0;
      arm_r <= 1'b0;
      got_r <= 1'b0;
      res_sh_r <= '0;
      sdo_r <= 1'b0;
      oe_n_r <= 1'b1;
      ready_r <= 1'b0;
    end else begin
      pop_r <= go_active & rbuf.out_valid;
      arm_r <= go_active;
      // Buffer read data stands one cycle after the pop, so the load waits for it
      load_r <= arm_r;
      got_r <= pop_r;
      oe_n_r <= cs_f;
      ready_r <= rbuf.in_ready;
      if (load_r) begin
        // An empty buffer shifts out zeros rather than stale data
        res_sh_r <= got_r ? rbuf.out_data : '0;
        sdo_r <= got_r ? rbuf.out_data[RES_W-1] : 1'b0;
      end else if (active & sclk_rise) begin
        res_sh_r <= {res_sh_r[RES_W-2:0], 1'b0};
        sdo_r <= res_sh_r[RES_W-2];
      end
    end
  end

  // Sampling trigger path, independent of select, sync and shift clock
  logic sampling_r;
  logic conv_start_r;
  logic eoc_n_r;
  logic tick_r;
  wire samp_begin = ext_sampling_mode & trig_fall & ~sampling_r;
  wire samp_end = sampling_r & trig_rise;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sampling_r <= 1'b0;
      conv_start_r <= 1'b0;
      eoc_n_r <= 1'b1;
      tick_r <= 1'b0;
    end else begin
      if (samp_begin) begin
        sampling_r <= 1'b1;
      end else if (samp_end) begin
        sampling_r <= 1'b0;
      end
      conv_start_r <= samp_end;
      // A done arriving with a new end of sampling still leaves the flag low
      if (samp_end & eoc_enable) begin
        eoc_n_r <= 1'b0;
      end else if (conv_done | ~eoc_enable) begin
        eoc_n_r <= 1'b1;
      end
      tick_r <= ext_conv_clk_sel & sclk_rise;
    end
  end

  assign result_ready = ready_r;
  assign serial_result_out = sdo_r;
  assign serial_result_oe_n = oe_n_r;
  assign cmd_word = cmd_word_r;
  assign cmd_valid = cmd_valid_r;
  assign sampling = sampling_r;
  assign conv_start = conv_start_r;
  assign eoc_n = eoc_n_r;
  assign conv_clk_tick = tick_r;
  assign frame_state = state_r;

  a_oe_released: assert property (@(posedge mclk) disable iff (reset)
    cs_f |=> serial_result_oe_n)
    else $error("output driven while deselected");
  a_cmd_ignored: assert property (@(posedge mclk) disable iff (reset)
    cs_f |=> !cmd_valid && $stable(cmd_word))
    else $error("command accepted while deselected");
  a_fall_clears: assert property (@(posedge mclk) disable iff (reset)
    cs_fall |=> edge_cnt_r == '0 && !edge_full_r ##1 !serial_result_oe_n)
    else $error("select fall did not restart frame");
  a_cs_start: assert property (@(posedge mclk) disable iff (reset)
    cs_fall && fs_f |=> frame_state == AFS_ACTIVE)
    else $error("select fall with sync high did not start");
  a_fs_wait: assert property (@(posedge mclk) disable iff (reset)
    cs_fall && !fs_f |=> frame_state == AFS_ARMED)
    else $error("select fall with sync low did not wait");
  a_trig_sample: assert property (@(posedge mclk) disable iff (reset)
    ext_sampling_mode && trig_fall && !sampling |=> sampling)
    else $error("trigger fall did not start sampling");
  a_trig_convert: assert property (@(posedge mclk) disable iff (reset)
    sampling && trig_rise |=> conv_start && !sampling)
    else $error("trigger rise did not start conversion");
  a_samp_holds: assert property (@(posedge mclk) disable iff (reset)
    sampling && !trig_f |=> sampling)
    else $error("sampling ended while trigger low");
  a_cmd_stop: assert property (@(posedge mclk) disable iff (reset)
    cmd_valid |=> !cmd_valid [*2])
    else $error("command bits taken after sixteen edges");
  a_eoc_low: assert property (@(posedge mclk) disable iff (reset)
    eoc_enable && conv_start |-> !eoc_n)
    else $error("end of conversion not low after sampling");
  a_conv_tick: assert property (@(posedge mclk) disable iff (reset)
    ext_conv_clk_sel && sclk_rise |=> conv_clk_tick)
    else $error("conversion clock lost");
endmodule

// file: sim/afs_host.sv
`timescale 1ns/10ps
module afs_host (
  input wire logic mclk,
  input wire logic serial_result_out,
  output logic frame_select_n,
  output logic frame_sync_pulse,
  output logic shift_clk,
  output logic serial_command_in,
  output logic sample_trigger_n
);
  logic [15:0] rx_word;
  // Pins idle with select and trigger high, the link clock parked low
  initial begin
    frame_select_n = 1'b1;
    frame_sync_pulse = 1'b0;
    shift_clk = 1'b0;
    serial_command_in = 1'b0;
    sample_trigger_n = 1'b1;
    rx_word = 16'h0000;
  end
  // Half a link clock period of 800 ns
  task automatic half();
    repeat (4) @(negedge mclk);
  endtask
  // Link clock pulses without a frame, e.g. as a conversion clock
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      shift_clk = 1'b1;
      serial_command_in = ~serial_command_in;
      half();
      shift_clk = 1'b0;
      half();
    end
  endtask
  // One frame; with sync low at the select fall the start waits for sync to rise
  task automatic frame(input logic [15:0] cmd, input logic sync_hi, input int nbits);
    frame_sync_pulse = sync_hi;
    half();
    frame_select_n = 1'b0;
    if (!sync_hi) begin
      half();
      half();
      frame_sync_pulse = 1'b1;
    end
    repeat (3) half();
    // Result bit read before each rise, command bit latched at each fall
    for (int i = 0; i < nbits; i++) begin
      rx_word = {rx_word[14:0], serial_result_out};
      shift_clk = 1'b1;
      serial_command_in = cmd[15-i];
      half();
      shift_clk = 1'b0;
      half();
    end
    frame_select_n = 1'b1;
    frame_sync_pulse = 1'b0;
    // Released data line must not keep its last value
    serial_command_in = ~serial_command_in;
    half();
    half();
  endtask
  // Trigger low time sets the sampling period
  task automatic trig(input int low_cyc);
    sample_trigger_n = 1'b0;
    repeat (low_cyc) @(negedge mclk);
    sample_trigger_n = 1'b1;
  endtask
endmodule

// file: sim/afs_top_bench.sv
`timescale 1ns/10ps
module afs_top_bench;
  import afs_pkg::*;
  logic mclk = 0, reset = 1, ext_sampling_mode = 0, ext_conv_clk_sel = 0, eoc_enable = 0;
  logic conv_done = 0, result_valid = 0, result_ready, serial_result_out, serial_result_oe_n;
  logic frame_select_n, frame_sync_pulse, shift_clk, serial_command_in, sample_trigger_n;
  logic [15:0] result_data = 16'h0000, cmd_word;
  logic cmd_valid, sampling, conv_start, eoc_n, conv_clk_tick;
  afs_frame_state_t frame_state;
  int errors = 0, n_checks = 0, n_cmd = 0, n_tick = 0, n_samp = 0, n_start = 0, hi_cnt = 0;
  int n_oe_bad = 0;
  // A released result line has no pull: the host then sees the inverse of the last bit
  wire sdo_line = serial_result_oe_n ? ~serial_result_out : serial_result_out;
  always #50 mclk = ~mclk;
  afs_host HOST (.mclk(mclk), .serial_result_out(sdo_line),
    .frame_select_n(frame_select_n), .frame_sync_pulse(frame_sync_pulse),
    .shift_clk(shift_clk), .serial_command_in(serial_command_in),
    .sample_trigger_n(sample_trigger_n));
  afs_top DUT (.mclk(mclk), .reset(reset), .frame_select_n(frame_select_n),
    .frame_sync_pulse(frame_sync_pulse), .shift_clk(shift_clk),
    .serial_command_in(serial_command_in), .sample_trigger_n(sample_trigger_n),
    .ext_sampling_mode(ext_sampling_mode), .ext_conv_clk_sel(ext_conv_clk_sel),
    .eoc_enable(eoc_enable), .conv_done(conv_done), .result_valid(result_valid),
    .result_data(result_data), .result_ready(result_ready),
    .serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n),
    .cmd_word(cmd_word), .cmd_valid(cmd_valid), .sampling(sampling),
    .conv_start(conv_start), .eoc_n(eoc_n), .conv_clk_tick(conv_clk_tick),
    .frame_state(frame_state));
  // Pulse counters, read at the falling edge where outputs have settled
  always @(negedge mclk) begin
    n_cmd += (cmd_valid === 1'b1);
    n_tick += (conv_clk_tick === 1'b1);
    n_samp += (sampling === 1'b1);
    n_start += (conv_start === 1'b1);
    hi_cnt = frame_select_n ? hi_cnt + 1 : 0;
    n_oe_bad += (!reset && hi_cnt > 8 && serial_result_oe_n !== 1'b1);
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic push(input logic [15:0] d);
    result_valid = 1'b1;
    result_data = d;
    @(negedge mclk);
    result_valid = 1'b0;
    // Let an edge pass so a following push never rewrites valid in this time step
    @(negedge mclk);
  endtask
  // Slave-select style frame: start at the select fall, result out MSB first
  task automatic t_spi();
    int c0 = n_cmd;
    push(16'hC3A5);
    fork
      HOST.frame(16'h9E61, 1'b1, 16);
      begin
        repeat (16) @(negedge mclk);
        check("state", frame_state, AFS_ACTIVE);
        check("oe_n", serial_result_oe_n, 1'b0);
      end
    join
    check("rx", HOST.rx_word, 16'hC3A5);
    check("cmd", cmd_word, 16'h9E61);
    check("ncmd", 16'(n_cmd - c0), 16'h0001);
    check("idle", frame_state, AFS_IDLE);
  endtask
  // Sync low at select fall: armed until sync rises; short frame gives no command
  task automatic t_dsp();
    int c0 = n_cmd;
    fork
      HOST.frame(16'h1234, 1'b0, 8);
      begin
        repeat (10) @(negedge mclk);
        check("armed", frame_state, AFS_ARMED);
        repeat (12) @(negedge mclk);
        check("act", frame_state, AFS_ACTIVE);
      end
    join
    check("ncmd", 16'(n_cmd - c0), 16'h0000);
    check("rx", HOST.rx_word[7:0], 8'h00);
  endtask
  // Link clock with select high: no data moves, conversion clock still ticks
  task automatic t_idle_clk();
    int c0 = n_cmd;
    int k0 = n_tick;
    ext_conv_clk_sel = 1'b1;
    HOST.pulses(4);
    check("tick", 16'(n_tick - k0), 16'h0004);
    check("ncmd", 16'(n_cmd - c0), 16'h0000);
    check("idle", frame_state, AFS_IDLE);
    ext_conv_clk_sel = 1'b0;
  endtask
  // Trigger during a running frame, then ignored outside extended mode
  task automatic t_trig();
    int s0 = n_samp;
    int t0 = n_start;
    ext_sampling_mode = 1'b1;
    eoc_enable = 1'b1;
    fork
      HOST.frame(16'h5A0F, 1'b1, 16);
      begin
        repeat (110) @(negedge mclk); // after the twelfth rise
        HOST.trig(20);
        repeat (8) @(negedge mclk);
        check("eoc", eoc_n, 1'b0);
        conv_done = 1'b1; // trigger kept high until done
        @(negedge mclk);
        conv_done = 1'b0;
        @(negedge mclk);
        check("eoc", eoc_n, 1'b1);
      end
    join
    check("samp", 16'(n_samp - s0), 16'h0014);
    check("start", 16'(n_start - t0), 16'h0001);
    check("cmd", cmd_word, 16'h5A0F);
    // Flag not in use: a conversion still starts but the flag stays high
    eoc_enable = 1'b0;
    HOST.trig(5);
    repeat (8) @(negedge mclk);
    check("eoc_off", eoc_n, 1'b1);
    check("start2", 16'(n_start - t0), 16'h0002);
    conv_done = 1'b1; // next fall only after done
    @(negedge mclk);
    conv_done = 1'b0;
    ext_sampling_mode = 1'b0;
    HOST.trig(10);
    repeat (10) @(negedge mclk);
    check("off", 16'(n_samp - s0), 16'h0019);
  endtask
  // Fill the buffer until refused, then drain it in order through frames
  task automatic t_fill();
    int n = 0;
    while (result_ready === 1'b1 && n < 40) begin
      push(16'h8001 + n[15:0]);
      n++;
    end
    check("full", result_ready, 1'b0);
    for (int i = 0; i < 33; i++) begin
      HOST.frame(16'h0000, 1'b1, 16);
      check("drain", HOST.rx_word, (i < 32) ? 16'h8001 + i[15:0] : 16'h0000);
    end
  endtask
  initial begin
    repeat (3) @(negedge mclk);
    reset = 1'b0;
    repeat (6) @(negedge mclk);
    t_spi();
    t_dsp();
    t_idle_clk();
    t_trig();
    t_fill();
    check("oe_bad", n_oe_bad[15:0], 16'h0000);
    final_report();
  end
  // Watchdog well beyond the roughly 5600 cycles of the sequence
  initial begin
    #1ms;
    errors++;
    final_report();
  end
endmodule
